// ---- common/timer_two_pkg.sv ----
// Package for the timer two and comparator control block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
`default_nettype none
package timer_two_pkg;
    // Register word indices; the byte address is four times the index.
    localparam logic [7:0] idx_timer_two_scale = 8'h17;
    localparam logic [7:0] idx_comparator_control = 8'h18;
    localparam logic [7:0] idx_comparator_select = 8'h19;
    localparam logic [7:0] idx_timer_two_control = 8'h1c;
    localparam logic [7:0] idx_timer_two_counter = 8'h1d;
    localparam logic [7:0] idx_timer_two_bound = 8'h09;
    localparam int addr_lsb = 2;
    localparam int addr_w = 10;
    // Field positions.
    localparam int clk_sel_hi = 7;
    localparam int clk_sel_lo = 4;
    localparam int out_sel_hi = 3;
    localparam int out_sel_lo = 2;
    localparam int mode_bit = 1;
    localparam int inv_bit = 0;
    localparam int res_bit = 7;
    localparam int pre_hi = 6;
    localparam int pre_lo = 5;
    localparam int scal_hi = 4;
    localparam int scal_lo = 0;
    localparam int cmp_en_bit = 7;
    localparam int cmp_res_bit = 6;
    localparam int cmp_samp_bit = 5;
    localparam int cmp_inv_bit = 4;
    localparam int cmp_minus_hi = 3;
    localparam int cmp_minus_lo = 1;
    localparam int cmp_plus_bit = 0;
    localparam int cmp_out_bit = 7;
    localparam int cmp_wake_bit = 6;
    localparam int cmp_hi_bit = 5;
    localparam int cmp_lo_bit = 4;
    localparam int cmp_lvl_hi = 3;
    localparam int cmp_lvl_lo = 0;
    // Reset values.
    localparam logic [7:0] reg_reset = 8'h00;
    // Clock source codes.
    localparam logic [3:0] src_stop = 4'h0;
    localparam logic [3:0] src_sys = 4'h1;
    localparam logic [3:0] src_fast = 4'h2;
    localparam logic [3:0] src_ext = 4'h3;
    localparam logic [3:0] src_low = 4'h4;
    localparam logic [3:0] src_cmp = 4'h5;
    localparam logic [3:0] src_pa0_r = 4'h8;
    localparam logic [3:0] src_pa0_f = 4'h9;
    localparam logic [3:0] src_pb0_r = 4'ha;
    localparam logic [3:0] src_pb0_f = 4'hb;
    localparam logic [3:0] src_pa4_r = 4'hc;
    localparam logic [3:0] src_pa4_f = 4'hd;
    // Output pin codes.
    localparam logic [1:0] out_none = 2'h0;
    localparam logic [1:0] out_pb2 = 2'h1;
    localparam logic [1:0] out_pa3 = 2'h2;
    localparam logic [1:0] out_pb4 = 2'h3;
    // Bus answers and PWM tops.
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam logic [7:0] cnt_max8 = 8'hff;
    localparam logic [7:0] cnt_max7 = 8'h7f;
    localparam logic [7:0] cnt_max6 = 8'h3f;

    // Analog pin levels seen by the comparator selection logic.
    typedef struct packed {
        logic port_a_pin3;
        logic port_a_pin4;
        logic port_b_pin6;
        logic port_b_pin7;
        logic bandgap;
        logic ladder;
    } analog_in_t;

    // Digital pin inputs used as timer clock sources.
    typedef struct packed {
        logic port_a_pin0;
        logic port_b_pin0;
        logic port_a_pin4;
    } pin_in_t;

    // Pin drive outputs of the block.
    typedef struct packed {
        logic port_b_pin2;
        logic port_b_pin2_oe;
        logic port_a_pin3;
        logic port_a_pin3_oe;
        logic port_b_pin4;
        logic port_b_pin4_oe;
        logic port_a_pin0;
        logic port_a_pin0_oe;
    } pin_out_t;

    // Reference ladder settings handed to the analog front end.
    typedef struct packed {
        logic high_range;
        logic low_range;
        logic [3:0] level;
        logic enable;
    } ladder_cfg_t;

    // Bus slave phases.
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_resp = 2'b01
    } bus_phase_t;
endpackage : timer_two_pkg
`default_nettype wire

// ---- src/timer_two_ctrl.sv ----
// Timer two control, counter and comparator control with an AXI4-Lite register slave.
// Assumes pins and analog levels are synchronous to sys_clk; analog compare is modelled digitally.
`default_nettype none
// Overview of operation
// RULE_01: Clock code 0 stops, 1 system, 5 comparator.
// RULE_02: Codes 8-13 clock from pin edges.
// RULE_03: Output select routes timer to one pin.
// RULE_04: Control bit 1 selects period or PWM.
// RULE_05: Control bit 0 inverts timer output.
// RULE_06: Scale bit 7 selects PWM resolution.
// RULE_07: Prescaler then five-bit scalar divide clock.
// RULE_08: Comparator enable bit, resets to zero.
// RULE_09: Software disables digital input on analog pins.
// RULE_10: Read-only bit 6 reports comparator result.
// RULE_11: Bit 5 resamples result on timer clock.
// RULE_12: Bit 4 inverts comparator result output.
// RULE_13: Three-bit minus input selection.
// RULE_14: Bandgap minus input gives no wake-up; the code still wakes on result changes with minus code 2.
// RULE_15: Bit 0 picks plus input.
// RULE_16: Select bit 7 drives comparator onto pin.
// RULE_17: Wake on comparator result change when enabled.
// RULE_18: Select bits 5,4 pick ladder ranges.
// RULE_19: Four-bit level sets reference step.
// RULE_20: Readable, writable eight-bit counter resetting zero.
module timer_two_ctrl #(
    parameter bit pwm_resolution_option = 1'b0,
    parameter bit timer_fast_clock_option = 1'b0
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic internal_high_rc_osc,
    input wire logic internal_low_rc_osc,
    input wire logic external_osc,
    input wire timer_two_pkg::pin_in_t pins_in,
    input wire timer_two_pkg::analog_in_t analog_in,
    output timer_two_pkg::pin_out_t pins_out,
    output timer_two_pkg::ladder_cfg_t ladder_cfg,
    output logic wake_up,
    input wire logic [timer_two_pkg::addr_w-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [timer_two_pkg::addr_w-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import timer_two_pkg::*;

    // Whole state of the block in one record.
    typedef struct packed {
        logic [7:0] scale;
        logic [7:0] cmp_ctl;
        logic [7:0] cmp_sel;
        logic [7:0] tctl;
        logic [7:0] counter;
        logic [7:0] bound;
        logic [5:0] pre_cnt;
        logic [4:0] scal_cnt;
        logic [2:0] pin_prev;
        logic [3:0] osc_prev;
        logic cmp_sampled;
        logic cmp_prev;
        logic pwm_out;
        logic wake;
        bus_phase_t wph;
        logic [1:0] bresp;
        bus_phase_t rph;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Register address decode shared by both bus channels.
    function automatic logic [7:0] word_index(input logic [addr_w-1:0] a);
        word_index = 8'(a[addr_w-1:addr_lsb]);
    endfunction : word_index

    // True for any mapped register word.
    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == idx_timer_two_scale) || (i == idx_comparator_control) ||
                    (i == idx_comparator_select) || (i == idx_timer_two_control) ||
                    (i == idx_timer_two_counter) || (i == idx_timer_two_bound);
    endfunction : is_mapped

    // Combinational signals derived from the stored state and the inputs.
    logic cmp_raw, cmp_minus, cmp_plus, cmp_result, cmp_out, tclk_tick, tm_out, div_tick, do_write, do_read;
    logic [3:0] src;
    logic [1:0] osel;
    logic [7:0] top, widx, ridx;
    logic [5:0] pre_max;

    // Comparator input routing and result.
    always_comb begin
        case (st_reg.cmp_ctl[cmp_minus_hi:cmp_minus_lo])  // [RULE_13]
            3'h0: cmp_minus = analog_in.port_a_pin3;
            3'h1: cmp_minus = analog_in.port_a_pin4;
            3'h2: cmp_minus = analog_in.bandgap;
            3'h3: cmp_minus = analog_in.ladder;
            3'h4: cmp_minus = analog_in.port_b_pin6;
            3'h5: cmp_minus = analog_in.port_b_pin7;
            default: cmp_minus = 1'b1;  // Reserved codes hold the result low.
        endcase
        cmp_plus = st_reg.cmp_ctl[cmp_plus_bit] ? analog_in.port_a_pin4 : analog_in.ladder;  // [RULE_15]
        cmp_raw = st_reg.cmp_ctl[cmp_en_bit] & cmp_plus & ~cmp_minus;  // [RULE_08]
        cmp_result = cmp_raw ^ st_reg.cmp_ctl[cmp_inv_bit];  // [RULE_12]
        cmp_out = st_reg.cmp_ctl[cmp_samp_bit] ? st_reg.cmp_sampled : cmp_result;  // [RULE_11]
    end

    // Timer clock source selection as a one-cycle tick.
    always_comb begin
        src = st_reg.tctl[clk_sel_hi:clk_sel_lo];
        case (src)
            src_stop: tclk_tick = 1'b0;  // [RULE_01]
            src_sys: tclk_tick = 1'b1;  // [RULE_01]
            src_fast: tclk_tick = (internal_high_rc_osc & ~st_reg.osc_prev[0]) | timer_fast_clock_option;
            src_ext: tclk_tick = external_osc & ~st_reg.osc_prev[1];
            src_low: tclk_tick = internal_low_rc_osc & ~st_reg.osc_prev[2];
            src_cmp: tclk_tick = cmp_result & ~st_reg.osc_prev[3];  // [RULE_01]
            src_pa0_r: tclk_tick = pins_in.port_a_pin0 & ~st_reg.pin_prev[0];  // [RULE_02]
            src_pa0_f: tclk_tick = ~pins_in.port_a_pin0 & st_reg.pin_prev[0];  // [RULE_02]
            src_pb0_r: tclk_tick = pins_in.port_b_pin0 & ~st_reg.pin_prev[1];  // [RULE_02]
            src_pb0_f: tclk_tick = ~pins_in.port_b_pin0 & st_reg.pin_prev[1];  // [RULE_02]
            src_pa4_r: tclk_tick = pins_in.port_a_pin4 & ~st_reg.pin_prev[2];  // [RULE_02]
            src_pa4_f: tclk_tick = ~pins_in.port_a_pin4 & st_reg.pin_prev[2];  // [RULE_02]
            default: tclk_tick = 1'b0;  // Reserved codes stop the timer.
        endcase
        // Prescaler limits 1, 4, 16, 64 minus one.
        case (st_reg.scale[pre_hi:pre_lo])  // [RULE_07]
            2'h0: pre_max = 6'h00;
            2'h1: pre_max = 6'h03;
            2'h2: pre_max = 6'h0f;
            default: pre_max = 6'h3f;
        endcase
        div_tick = tclk_tick && (st_reg.pre_cnt == pre_max) &&
                   (st_reg.scal_cnt == st_reg.scale[scal_hi:scal_lo]);  // [RULE_07]
        // PWM top count from the resolution bit.
        if (st_reg.scale[res_bit]) begin  // [RULE_06]
            top = pwm_resolution_option ? cnt_max7 : cnt_max6;
        end else begin
            top = cnt_max8;
        end
        tm_out = st_reg.pwm_out ^ st_reg.tctl[inv_bit];  // [RULE_05]
        osel = st_reg.tctl[out_sel_hi:out_sel_lo];
    end

    // A write is taken only with both halves present.
    assign widx = word_index(s_axi_awaddr);
    assign ridx = word_index(s_axi_araddr);
    assign do_write = (st_reg.wph == bus_idle) && s_axi_awvalid && s_axi_wvalid;
    assign do_read = (st_reg.rph == bus_idle) && s_axi_arvalid;
    assign s_axi_awready = do_write;
    assign s_axi_wready = do_write;
    assign s_axi_arready = do_read;
    assign s_axi_bvalid = (st_reg.wph == bus_resp);
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = (st_reg.rph == bus_resp);
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;

    // Outputs from registered state, except port_a_pin0, which can follow cmp_result combinationally.
    always_comb begin
        pins_out.port_b_pin2 = tm_out;  // [RULE_03]
        pins_out.port_b_pin2_oe = (osel == out_pb2);  // [RULE_03]
        pins_out.port_a_pin3 = tm_out;
        pins_out.port_a_pin3_oe = (osel == out_pa3);  // [RULE_03]
        pins_out.port_b_pin4 = tm_out;
        pins_out.port_b_pin4_oe = (osel == out_pb4);  // [RULE_03]
        pins_out.port_a_pin0 = cmp_out;  // [RULE_16]
        pins_out.port_a_pin0_oe = st_reg.cmp_sel[cmp_out_bit];  // [RULE_16]
        ladder_cfg.high_range = st_reg.cmp_sel[cmp_hi_bit];  // [RULE_18]
        ladder_cfg.low_range = st_reg.cmp_sel[cmp_lo_bit];  // [RULE_18]
        ladder_cfg.level = st_reg.cmp_sel[cmp_lvl_hi:cmp_lvl_lo];  // [RULE_19]
        ladder_cfg.enable = st_reg.cmp_ctl[cmp_en_bit];
        wake_up = st_reg.wake;
    end

    // Next-state logic for all registers, counters and bus phases.
    always_comb begin
        st_next = st_reg;
        st_next.pin_prev = {pins_in.port_a_pin4, pins_in.port_b_pin0, pins_in.port_a_pin0};
        st_next.osc_prev = {cmp_result, internal_low_rc_osc, external_osc, internal_high_rc_osc};
        if (tclk_tick) begin
            st_next.cmp_sampled = cmp_result;  // [RULE_11]
        end
        // Wake pulse on any change of the result bit.
        st_next.cmp_prev = cmp_raw;
        st_next.wake = st_reg.cmp_sel[cmp_wake_bit] && (cmp_raw != st_reg.cmp_prev);  // [RULE_17]
        // Divider chain and counter.
        if (tclk_tick) begin
            if (st_reg.pre_cnt == pre_max) begin  // [RULE_07]
                st_next.pre_cnt = '0;
                st_next.scal_cnt = (st_reg.scal_cnt == st_reg.scale[scal_hi:scal_lo]) ? 5'h00 :
                                   5'(st_reg.scal_cnt + 5'h01);
            end else begin
                st_next.pre_cnt = 6'(st_reg.pre_cnt + 6'h01);
            end
        end
        if (div_tick) begin
            if (st_reg.tctl[mode_bit]) begin  // [RULE_04]
                // PWM mode: wrap at top, output high while below bound.
                st_next.counter = (st_reg.counter >= top) ? 8'h00 : 8'(st_reg.counter + 8'h01);  // [RULE_20]
                st_next.pwm_out = ((st_reg.counter & top) < (st_reg.bound & top));
            end else begin
                // Period mode: toggle output on reaching bound.
                if (st_reg.counter == st_reg.bound) begin
                    st_next.counter = 8'h00;
                    st_next.pwm_out = ~st_reg.pwm_out;
                end else begin
                    st_next.counter = 8'(st_reg.counter + 8'h01);  // [RULE_20]
                end
            end
        end
        // Write channel.
        if (st_reg.wph == bus_resp) begin
            if (s_axi_bready) begin
                st_next.wph = bus_idle;
            end
        end else if (do_write) begin
            st_next.wph = bus_resp;
            st_next.bresp = is_mapped(widx) ? resp_okay : resp_slverr;
            if (s_axi_wstrb[0]) begin
                case (widx)
                    idx_timer_two_scale: st_next.scale = s_axi_wdata[7:0];
                    idx_comparator_control: begin
                        // Result bit is read-only and never stored.
                        st_next.cmp_ctl = s_axi_wdata[7:0] & ~(8'h01 << cmp_res_bit);  // [RULE_10]
                    end
                    idx_comparator_select: st_next.cmp_sel = s_axi_wdata[7:0];
                    idx_timer_two_control: st_next.tctl = s_axi_wdata[7:0];
                    idx_timer_two_counter: st_next.counter = s_axi_wdata[7:0];  // [RULE_20]
                    idx_timer_two_bound: st_next.bound = s_axi_wdata[7:0];
                    default: st_next.bresp = resp_slverr;
                endcase
            end
        end
        // Read channel.
        if (st_reg.rph == bus_resp) begin
            if (s_axi_rready) begin
                st_next.rph = bus_idle;
            end
        end else if (do_read) begin
            st_next.rph = bus_resp;
            st_next.rresp = resp_okay;
            st_next.rdata = '0;
            case (ridx)
                idx_timer_two_scale: st_next.rdata[7:0] = st_reg.scale;
                idx_comparator_control: begin
                    st_next.rdata[7:0] = st_reg.cmp_ctl;
                    st_next.rdata[cmp_res_bit] = cmp_raw;  // [RULE_10]
                end
                idx_comparator_select: st_next.rdata[7:0] = st_reg.cmp_sel;
                idx_timer_two_control: st_next.rdata[7:0] = st_reg.tctl;
                idx_timer_two_counter: st_next.rdata[7:0] = st_reg.counter;  // [RULE_20]
                idx_timer_two_bound: st_next.rdata[7:0] = st_reg.bound;
                default: st_next.rresp = resp_slverr;
            endcase
        end
    end

    // State register with synchronous reset and clock enable.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;  // [RULE_08] [RULE_20]
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end
endmodule : timer_two_ctrl
`default_nettype wire

// ---- test/front_model.sv ----
// Far side of the block: pin inputs, oscillator stand-ins, analog levels.
// Assumes the bench asks for pin pulses and a comparator level.
`default_nettype none
module front_model (
    input wire logic sys_clk,
    input wire logic cmp_level,
    input wire logic [2:0] pulse_req,
    output timer_two_pkg::analog_in_t analog_in,
    output timer_two_pkg::pin_in_t pins_in,
    output logic [2:0] osc
);
    import timer_two_pkg::*;
    logic [3:0] div_reg = 4'h0;
    pin_in_t pin_reg = '0;
    // Free-running oscillators; pins idle low, digital inputs quiet on analog duty.
    always_ff @(posedge sys_clk) begin
        div_reg <= div_reg + 4'h1;
        pin_reg <= pulse_req;
    end
    assign pins_in = pin_reg;
    assign osc = {div_reg[0], div_reg[3], div_reg[1]};
    // Only the ladder follows the level.
    assign analog_in = '{ladder: cmp_level, default: 1'b0};
endmodule : front_model
`default_nettype wire

// ---- test/timer_two_checker.sv ----
// Concurrent checks on the ports of the timer two control block.
// Assumes it is bound to timer_two_ctrl and that clk_en stays high.
`default_nettype none
module timer_two_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire timer_two_pkg::pin_out_t pins_out,
    input wire timer_two_pkg::ladder_cfg_t ladder_cfg,
    input wire logic wake_up,
    input wire logic [timer_two_pkg::addr_w-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    import timer_two_pkg::*;
    // Shadows of written registers and of a missed map.
    logic [7:0] ctl_reg, cs_reg, bnd_reg;
    logic bad_reg;
    logic wr_take;
    logic [7:0] wr_idx;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign wr_idx = s_axi_awaddr[addr_w-1:addr_lsb];
    // Track every accepted write.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {ctl_reg, cs_reg, bnd_reg, bad_reg} <= '0;
        end else if (wr_take) begin
            bad_reg <= !(wr_idx inside {idx_timer_two_scale, idx_comparator_control, idx_comparator_select,
                idx_timer_two_control, idx_timer_two_counter, idx_timer_two_bound});
            if (wr_idx == idx_timer_two_control) ctl_reg <= s_axi_wdata[7:0];
            if (wr_idx == idx_comparator_select) cs_reg <= s_axi_wdata[7:0];
            if (wr_idx == idx_timer_two_bound) bnd_reg <= s_axi_wdata[7:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Judged once the response is gone.
    out_route_a: assert property (!s_axi_bvalid |->
        {pins_out.port_b_pin2_oe, pins_out.port_a_pin3_oe, pins_out.port_b_pin4_oe} ==
        {ctl_reg[3:2] == out_pb2, ctl_reg[3:2] == out_pa3, ctl_reg[3:2] == out_pb4})
        else $error("timer pin enables wrong");
    cmp_pin_a: assert property (!s_axi_bvalid |-> pins_out.port_a_pin0_oe == cs_reg[cmp_out_bit])
        else $error("comparator pin enable wrong");
    ladder_map_a: assert property (!s_axi_bvalid |->
        {ladder_cfg.high_range, ladder_cfg.low_range, ladder_cfg.level} == cs_reg[5:0])
        else $error("ladder settings wrong");
    out_invert_a: assert property (!s_axi_bvalid && ctl_reg[3:1] == 3'h3 && bnd_reg == 8'h00 |->
        pins_out.port_b_pin2 == ctl_reg[inv_bit])
        else $error("zero-duty level wrong");
    wake_gate_a: assert property (wake_up |-> cs_reg[cmp_wake_bit] || $past(cs_reg[cmp_wake_bit]))
        else $error("wake while disabled");
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bad_addr_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (bad_reg ? resp_slverr : resp_okay))
        else $error("bresp wrong");
    wr_single_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while busy");
    cover property (wake_up);
    cover property ($rose(s_axi_bvalid) && bad_reg);
    cover property (ctl_reg[3:1] == 3'h3);
endmodule : timer_two_checker

bind timer_two_ctrl timer_two_checker timer_two_checker_i (.*);
`default_nettype wire

// ---- test/timer_two_with_comparator_control_tb.sv ----
// Self-checking bench for the timer two control block over AXI4-Lite.
// Assumes the checker is bound to the design and clk_en stays high.
`default_nettype none
module timer_two_with_comparator_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_two_pkg::*;
    logic sys_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, cmp_level = 1'h0, res, wake_up;
    logic [2:0] osc, m, pulse_req = 3'h0;
    logic internal_high_rc_osc, internal_low_rc_osc, external_osc;
    pin_in_t pins_in;
    analog_in_t analog_in;
    pin_out_t pins_out;
    ladder_cfg_t ladder_cfg;
    logic [addr_w-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] rd_val;
    int n_fail = 0, checked = 0, cycles = 0, wakes = 0, w0, e;
    assign {internal_high_rc_osc, internal_low_rc_osc, external_osc} = osc;
    timer_two_ctrl timer_two_ctrl_i (.*);
    front_model front_model_i (.*);
    // Clock, wake pulse count and the hang limit.
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (wake_up === 1'h1) wakes <= wakes + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    // Compare and count.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One write; each channel released when taken.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = resp_okay);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", er, s_axi_bresp);
        @(posedge sys_clk);
    endtask : wr
    // One read; data taken with rvalid.
    task automatic rd(input logic [7:0] idx, input logic [1:0] er = resp_okay);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_val = s_axi_rdata[7:0];
        s_axi_rready <= 1'h0;
        chk("rresp", er, s_axi_rresp);
        @(posedge sys_clk);
    endtask : rd
    task automatic rdx(input logic [7:0] idx, input logic [7:0] exp, input string what,
                       input logic [1:0] er = resp_okay);
        rd(idx, er);
        chk(what, exp, rd_val);
    endtask : rdx
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // Main sequence.
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        rdx(idx_timer_two_control, reg_reset, "control");
        rdx(idx_comparator_control, reg_reset, "cmp_ctl");
        rdx(idx_timer_two_counter, reg_reset, "counter");
        wr(idx_timer_two_counter, 8'h5a);
        rdx(idx_timer_two_counter, 8'h5a, "counter");
        wr(8'h30, 8'hff, resp_slverr);
        rdx(8'h30, 8'h00, "unmapped", resp_slverr);
        for (int c = 0; c < 16; c++) begin
            if (c == 6 || c == 7) continue;
            wr(idx_timer_two_control, {c[3:0], 4'h0});
            rdx(idx_timer_two_control, {c[3:0], 4'h0}, "clk_sel");
        end
        // Pin clocks: one, two and three pulses on the three pins.
        wr(idx_timer_two_bound, 8'hff);
        for (int p = 0; p < 6; p++) begin
            wr(idx_timer_two_control, 8'h00);
            wr(idx_timer_two_counter, 8'h00);
            wr(idx_timer_two_control, {src_pa0_r + p[3:0], 4'h0});
            for (int r = 0; r < 3; r++) begin
                pulse_req <= 3'h7 >> r;
                repeat (3) @(posedge sys_clk);
                pulse_req <= 3'h0;
                repeat (3) @(posedge sys_clk);
            end
            rdx(idx_timer_two_counter, 8'(p / 2 + 1), "pin_edges");
        end
        // System clock through each prescale.
        for (int p = 0; p < 4; p++) begin
            wr(idx_timer_two_scale, {1'h0, p[1:0], 5'h00});
            wr(idx_timer_two_counter, 8'h00);
            wr(idx_timer_two_control, {src_sys, 4'h0});
            repeat (128) @(posedge sys_clk);
            wr(idx_timer_two_control, 8'h00);
            rd(idx_timer_two_counter);
            e = 128 >> (2 * p);
            chk("prescale", 1, rd_val >= e && rd_val <= e + 8);
            rdx(idx_timer_two_counter, rd_val, "stopped");
        end
        wr(idx_timer_two_scale, 8'h80);
        wr(idx_timer_two_control, {src_sys, 4'h2});
        repeat (200) @(posedge sys_clk);
        wr(idx_timer_two_control, 8'h00);
        rd(idx_timer_two_counter);
        chk("pwm_top", 1, rd_val <= cnt_max6);
        wr(idx_timer_two_bound, 8'h00);
        wr(idx_timer_two_control, {src_sys, 4'h2});
        for (int k = 0; k < 8; k++) begin
            wr(idx_timer_two_control, {4'h0, k[2:1], 1'h1, k[0]});
            m = 3'(4'h8 >> k[2:1]);
            chk("oe", m, {pins_out.port_b_pin2_oe, pins_out.port_a_pin3_oe, pins_out.port_b_pin4_oe});
            chk("level", {3{k[0]}} & m, {pins_out.port_b_pin2, pins_out.port_a_pin3, pins_out.port_b_pin4} & m);
        end
        // All minus codes, both plus inputs; result bit read-only.
        wr(idx_comparator_select, 8'h80);
        for (int k = 0; k < 32; k++) begin
            cmp_level <= k[4];
            res = k[4] && !k[0] && k[3:1] != 3'h3 && k[3:1] < 3'h6;
            wr(idx_comparator_control, {2'h3, 1'h0, k[4:0]});
            rdx(idx_comparator_control, {1'h1, res, 1'h0, k[4:0]}, "cmp_ctl");
            chk("cmp_pin", {1'h1, res ^ k[4]}, {pins_out.port_a_pin0_oe, pins_out.port_a_pin0});
        end
        cmp_level <= 1'h1;
        wr(idx_comparator_control, 8'ha0);
        wr(idx_timer_two_control, {src_sys, 4'h0});
        repeat (4) @(posedge sys_clk);
        chk("sampled", 1, pins_out.port_a_pin0);
        wr(idx_timer_two_control, 8'h00);
        cmp_level <= 1'h0;
        repeat (8) @(posedge sys_clk);
        chk("held", 1, pins_out.port_a_pin0);
        wr(idx_comparator_control, 8'h80);
        chk("unsampled", 0, pins_out.port_a_pin0);
        for (int k = 0; k < 2; k++) begin
            wr(idx_comparator_select, {1'h0, k[0], 6'h00});
            w0 = wakes;
            cmp_level <= 1'h1;
            repeat (6) @(posedge sys_clk);
            cmp_level <= 1'h0;
            repeat (6) @(posedge sys_clk);
            chk("wakes", 2 * k, wakes - w0);
        end
        for (int lv = 0; lv < 16; lv++) begin
            wr(idx_comparator_select, {2'h0, lv[3:2], lv[3:0]});
            chk("ladder", {lv[3:2], lv[3:0]}, {ladder_cfg.high_range, ladder_cfg.low_range, ladder_cfg.level});
        end
        summarize();
    end
endmodule : timer_two_with_comparator_control_tb
`default_nettype wire
